// *** hdl/plac_ctrl.sv ***
// Decided for this implementation: the Wishbone register port.
`include "plac_defs.svh"
`default_nettype none
module plac_ctrl #(
    parameter int RAM_AW = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Data path status
    input wire logic tx_path_en_i,
    input wire logic rx_path_en_i,
    input wire logic rx_path_active_i,
    input wire logic sclk_div4_i,
    input wire logic symbol_tick_i,
    input wire logic [2:0] frame_sync_i,
    // Digital loopback samples
    input wire logic sample_tick_i,
    input wire plac_pkg::plac_iq_t tx_op_i,
    input wire plac_pkg::plac_iq_t rx_data_i,
    output logic [15:0] rx_port_data_o,
    output logic rx_port_q_o,
    // Waveform memory and DAC1
    input wire logic [9:0] ram_data_i,
    input wire logic [9:0] dac1_value_i,
    output logic [RAM_AW-1:0] ram_addr_o,
    output logic [9:0] dac1_data_o,
    // Auxiliary ADC
    output logic adc_pwr_o,
    output logic adc_clk_o,
    output logic adc_converting_o,
    output logic [2:0] adc_chan_o,
    output logic adc_done_o,
    // Enables into the data paths
    output plac_pkg::plac_power_t power_o,
    output plac_pkg::plac_route_t route_o
);
    import plac_pkg::*;

    if (RAM_AW < 2 || RAM_AW > 12) begin : g_check
        $error("RAM_AW must lie between 2 and 12");
    end

    logic [7:0] clock_gating_control_reg;
    logic [7:0] power_up_control_reg;
    logic [7:0] loopback_routing_control_reg;
    logic [7:0] waveform_dac_scan_control_reg;
    logic [7:0] aux_converter_channel_enable_reg;
    logic [7:0] aux_converter_run_control_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [7:0] rd_next;
    logic bus_req;
    logic wr_commit;
    logic hit;

    // Bus: one wait cycle, then a single-cycle ack
    assign bus_req = cyc_i && stb_i && !ack_reg;
    assign wr_commit = cyc_i && stb_i && we_i && ack_reg && sel_i[0];
    assign hit = adr_i[1:0] == 2'b00;
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    always_comb begin
        rd_next = 8'h00;
        if (hit) begin
            case (adr_i[7:2])
                `PLAC_IDX_CLK: rd_next = clock_gating_control_reg;
                `PLAC_IDX_PWR: rd_next = power_up_control_reg;
                `PLAC_IDX_LOOP: rd_next = loopback_routing_control_reg;
                `PLAC_IDX_SCAN: rd_next = waveform_dac_scan_control_reg;
                `PLAC_IDX_CHAN: rd_next = aux_converter_channel_enable_reg;
                `PLAC_IDX_RUN: rd_next = aux_converter_run_control_reg;
                default: rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req;
            if (bus_req) begin
                dat_reg <= {24'h00_0000, rd_next};
            end
        end
    end

    // Plain read/write bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_gating_control_reg <= `PLAC_RST_VAL;
            power_up_control_reg <= `PLAC_RST_VAL;
            loopback_routing_control_reg <= `PLAC_RST_VAL;
            waveform_dac_scan_control_reg <= `PLAC_RST_VAL;
            aux_converter_channel_enable_reg <= `PLAC_RST_VAL;
        end else if (wr_commit && hit) begin
            case (adr_i[7:2])
                `PLAC_IDX_CLK: clock_gating_control_reg <= dat_i[7:0]; // RQ23
                `PLAC_IDX_PWR: power_up_control_reg <= dat_i[7:0];
                `PLAC_IDX_LOOP: loopback_routing_control_reg <= dat_i[7:0];
                `PLAC_IDX_SCAN: waveform_dac_scan_control_reg <= dat_i[7:0];
                `PLAC_IDX_CHAN: aux_converter_channel_enable_reg <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Clock gating and power
    logic aux_stop;
    logic ser_mode;
    logic [2:0] idle_sym_reg;
    logic ser_asleep_reg;
    assign aux_stop = clock_gating_control_reg[`PLAC_CLK_AUX];
    // Auto stop only defined with the serial clock at MCLK/4
    assign ser_mode = clock_gating_control_reg[`PLAC_CLK_SER_AUTO] && sclk_div4_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idle_sym_reg <= 3'h0;
            ser_asleep_reg <= 1'b0;
        end else if (!ser_mode || |frame_sync_i) begin
            idle_sym_reg <= 3'h0; // RQ5
            ser_asleep_reg <= 1'b0; // RQ5
        end else if (symbol_tick_i && !ser_asleep_reg) begin
            // First period is partial, giving the 5 to 6 symbol window
            idle_sym_reg <= idle_sym_reg + 3'h1;
            ser_asleep_reg <= (idle_sym_reg + 3'h1) == `PLAC_SER_IDLE_SYM; // RQ5
        end
    end

    always_comb begin
        power_o.tx_clk_en = !clock_gating_control_reg[`PLAC_CLK_TX_AUTO] || tx_path_en_i; // RQ1
        power_o.rx_clk_en = !clock_gating_control_reg[`PLAC_CLK_RX_AUTO] || rx_path_en_i; // RQ6
        power_o.fifo_clk_en = !clock_gating_control_reg[`PLAC_CLK_FIFO_OFF]; // RQ2
        power_o.rx_port_pwr = !(clock_gating_control_reg[`PLAC_CLK_RXPORT] && !rx_path_active_i); // RQ3
        power_o.serial_pwr = !ser_asleep_reg;
        power_o.bias_en = power_up_control_reg[`PLAC_PWR_BIAS];
        power_o.aux_dac_pwr = power_up_control_reg[3:0]; // RQ8
        power_o.scan_dac_pwr = !aux_stop; // RQ4
        route_o.rx_filter_bypass = loopback_routing_control_reg[`PLAC_LB_RXFILT]; // RQ9
        route_o.iir_bypass = loopback_routing_control_reg[`PLAC_LB_IIR]; // RQ10
        route_o.codec_rate_32k = loopback_routing_control_reg[`PLAC_LB_IIR]; // RQ10
        route_o.codec_16bit = loopback_routing_control_reg[`PLAC_LB_IIR]; // RQ10
        route_o.codec_loop = loopback_routing_control_reg[`PLAC_LB_CODEC]; // RQ11
        route_o.analog_loop = loopback_routing_control_reg[`PLAC_LB_ANALOG]; // RQ11
        route_o.rx_access_wr_en = loopback_routing_control_reg[`PLAC_LB_RXACC]; // RQ12
        route_o.tx_access_wr_en = loopback_routing_control_reg[`PLAC_LB_TXACC]; // RQ12
        route_o.digital_loop = loopback_routing_control_reg[`PLAC_LB_DIGITAL];
    end

    // Receive port: I then Q on successive sample strobes
    logic q_phase_reg;
    logic [15:0] rx_out_reg;
    plac_iq_t rx_src;
    assign rx_src = route_o.digital_loop ? tx_op_i : rx_data_i; // RQ13
    assign rx_port_data_o = rx_out_reg;
    assign rx_port_q_o = q_phase_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_phase_reg <= 1'b1;
            rx_out_reg <= 16'h0000;
        end else if (sample_tick_i) begin
            q_phase_reg <= !q_phase_reg; // RQ13
            rx_out_reg <= q_phase_reg ? rx_src.i : rx_src.q; // RQ13
        end
    end

    // Waveform memory scan
    logic [8:0] scan_div_reg;
    logic [8:0] scan_mask;
    logic scan_tick;
    logic scan_up_reg;
    logic [RAM_AW-1:0] ptr_reg;
    logic at_top;
    logic at_bottom;
    logic scan_run;
    assign scan_mask = `PLAC_SCAN_DIV_MAX >> waveform_dac_scan_control_reg[`PLAC_SCAN_RATE_HI:`PLAC_SCAN_RATE_LO];
    assign scan_tick = (scan_div_reg & scan_mask) == scan_mask; // RQ14
    assign at_top = &ptr_reg;
    assign at_bottom = ~|ptr_reg;
    assign scan_run = waveform_dac_scan_control_reg[`PLAC_SCAN_SRC] && !aux_stop;
    assign ram_addr_o = ptr_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_div_reg <= 9'h000;
        end else begin
            scan_div_reg <= scan_div_reg + 9'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_reg <= '0;
            scan_up_reg <= 1'b0;
        end else if (scan_run && scan_tick) begin
            if (waveform_dac_scan_control_reg[`PLAC_SCAN_CYCLE]) begin
                if (scan_up_reg && at_top) begin
                    scan_up_reg <= 1'b0; // RQ16
                    ptr_reg <= ptr_reg - 1'b1;
                end else if (!scan_up_reg && at_bottom) begin
                    scan_up_reg <= 1'b1; // RQ16
                    ptr_reg <= ptr_reg + 1'b1;
                end else begin
                    ptr_reg <= scan_up_reg ? ptr_reg + 1'b1 : ptr_reg - 1'b1;
                end
            end else if ((scan_up_reg && at_top) || (!scan_up_reg && at_bottom)) begin
                // Scan finished: only now adopt the written direction
                scan_up_reg <= waveform_dac_scan_control_reg[`PLAC_SCAN_UP]; // RQ15
            end else begin
                ptr_reg <= scan_up_reg ? ptr_reg + 1'b1 : ptr_reg - 1'b1;
            end
        end
    end

    logic [9:0] dac1_reg;
    assign dac1_data_o = dac1_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac1_reg <= 10'h000;
        end else begin
            dac1_reg <= waveform_dac_scan_control_reg[`PLAC_SCAN_SRC] ? ram_data_i : dac1_value_i; // RQ17
        end
    end

    // Auxiliary ADC sequencer
    plac_adc_state_t adc_state_reg;
    logic [7:0] conv_cnt_reg;
    logic [7:0] conv_period;
    logic [3:0] adc_div_reg;
    logic [3:0] adc_div_mask;
    logic [1:0] warm_cnt_reg;
    logic [2:0] chan_reg;
    logic [`PLAC_NUM_CHAN-1:0] chan_act_reg;
    logic conv_end;
    logic pass_done;
    logic adc_req;
    logic slow;
    assign slow = aux_converter_run_control_reg[`PLAC_RUN_SLOW];
    assign conv_period = slow ? `PLAC_CONV_SLOW : `PLAC_CONV_FAST; // RQ19
    assign adc_div_mask = slow ? `PLAC_ADC_DIV_SLOW : `PLAC_ADC_DIV_FAST; // RQ19
    assign conv_end = conv_cnt_reg == conv_period - 8'h01;
    assign adc_req = (aux_converter_run_control_reg[`PLAC_RUN_CONT] ||
                      aux_converter_run_control_reg[`PLAC_RUN_START]) && !aux_stop;
    assign pass_done = adc_state_reg == PLAC_ADC_CONV && conv_end &&
                       chan_reg == 3'(`PLAC_NUM_CHAN - 1);
    assign adc_pwr_o = adc_state_reg != PLAC_ADC_IDLE; // RQ22
    assign adc_clk_o = adc_pwr_o && (adc_div_reg & adc_div_mask) == adc_div_mask;
    // Slot's first cycle reads the live enable, before the sampled copy lands
    assign adc_converting_o = adc_state_reg == PLAC_ADC_CONV &&
        (conv_cnt_reg == 8'h00 ? aux_converter_channel_enable_reg[chan_reg] : chan_act_reg[chan_reg]); // RQ18
    assign adc_chan_o = chan_reg;
    assign adc_done_o = adc_converting_o && conv_end;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_state_reg <= PLAC_ADC_IDLE;
            conv_cnt_reg <= 8'h00;
            adc_div_reg <= 4'h0;
            warm_cnt_reg <= 2'h0;
            chan_reg <= 3'h0;
        end else begin
            adc_div_reg <= adc_pwr_o ? adc_div_reg + 4'h1 : 4'h0;
            conv_cnt_reg <= (adc_pwr_o && !conv_end) ? conv_cnt_reg + 8'h01 : 8'h00;
            case (adc_state_reg)
                PLAC_ADC_IDLE: begin
                    warm_cnt_reg <= 2'h0;
                    chan_reg <= 3'h0;
                    if (adc_req) begin
                        adc_state_reg <= PLAC_ADC_WARM;
                    end
                end
                PLAC_ADC_WARM: begin
                    if (aux_stop) begin
                        adc_state_reg <= PLAC_ADC_IDLE; // RQ4
                    end else if (conv_end) begin
                        warm_cnt_reg <= warm_cnt_reg + 2'h1;
                        if (warm_cnt_reg + 2'h1 == `PLAC_WARM_PERIODS) begin
                            adc_state_reg <= PLAC_ADC_CONV; // RQ22
                        end
                    end
                end
                PLAC_ADC_CONV: begin
                    if (aux_stop) begin
                        adc_state_reg <= PLAC_ADC_IDLE; // RQ4
                    end else if (conv_end) begin
                        if (chan_reg == 3'(`PLAC_NUM_CHAN - 1)) begin
                            chan_reg <= 3'h0;
                            if (!aux_converter_run_control_reg[`PLAC_RUN_CONT]) begin
                                adc_state_reg <= PLAC_ADC_IDLE; // RQ21
                            end
                        end else begin
                            chan_reg <= chan_reg + 3'h1; // RQ20
                        end
                    end
                end
                default: adc_state_reg <= PLAC_ADC_IDLE;
            endcase
        end
    end

    // Per-channel enable, sampled as that channel's slot opens
    for (genvar k = 0; k < `PLAC_NUM_CHAN; k++) begin : g_chan
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                chan_act_reg[k] <= 1'b0;
            end else if (conv_cnt_reg == 8'h00 && chan_reg == 3'(k) &&
                         adc_state_reg == PLAC_ADC_CONV) begin
                chan_act_reg[k] <= aux_converter_channel_enable_reg[k]; // RQ18
            end
        end
    end

    // Start bit: a software write wins over the self-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_converter_run_control_reg <= `PLAC_RST_VAL;
        end else if (wr_commit && hit && adr_i[7:2] == `PLAC_IDX_RUN) begin
            aux_converter_run_control_reg <= dat_i[7:0];
        end else if (pass_done && !aux_converter_run_control_reg[`PLAC_RUN_CONT]) begin
            aux_converter_run_control_reg[`PLAC_RUN_START] <= 1'b0; // RQ21
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_warm_enter;
        adc_state_reg == PLAC_ADC_IDLE ##1 adc_state_reg == PLAC_ADC_WARM;
    endsequence
    sequence s_fast_tick;
        scan_tick && scan_run && waveform_dac_scan_control_reg[5:3] == 3'h7;
    endsequence

    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles"); // RQ23
    property p_tx_gate;
        clock_gating_control_reg[5] && !tx_path_en_i |-> !power_o.tx_clk_en;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx clock runs while disabled"); // RQ1
    property p_rx_gate;
        clock_gating_control_reg[0] && !rx_path_en_i |-> !power_o.rx_clk_en;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx clock runs while disabled"); // RQ6
    property p_fifo;
        power_o.fifo_clk_en != clock_gating_control_reg[4];
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo clock wrong"); // RQ2
    property p_ser_wake;
        ser_asleep_reg && |frame_sync_i |=> !ser_asleep_reg;
    endproperty
    a_ser_wake: assert property (p_ser_wake) else $error("serial did not wake"); // RQ5
    property p_aux_stop;
        aux_stop && adc_pwr_o |=> !adc_pwr_o;
    endproperty
    a_aux_stop: assert property (p_aux_stop) else $error("adc not stopped"); // RQ4
    property p_warm_len;
        s_warm_enter |-> (adc_state_reg == PLAC_ADC_WARM) [*8];
    endproperty
    a_warm_len: assert property (p_warm_len) else $error("warm-up too short"); // RQ22
    property p_fast_scan;
        s_fast_tick |=> !scan_tick ##1 !scan_tick ##1 !scan_tick ##1 scan_tick;
    endproperty
    a_fast_scan: assert property (p_fast_scan) else $error("scan rate wrong"); // RQ14
    property p_start_clear;
        pass_done && !aux_converter_run_control_reg[1] && !(wr_commit && adr_i[7:2] == 6'h16)
            |=> !aux_converter_run_control_reg[0] && adc_state_reg == PLAC_ADC_IDLE;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start not cleared"); // RQ21
    property p_conv_len;
        adc_done_o && !slow |-> $past(conv_cnt_reg) == 8'h56;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // RQ19
endmodule : plac_ctrl
`default_nettype wire

// *** hdl/plac_defs.svh ***
// Notes on behaviour
// [RQ1] Tx auto stop: Tx clock follows Tx enable
// [RQ2] FIFO clock bit high stops FIFO clock
// [RQ3] Rx port sleeps while Rx path inactive
// [RQ4] Aux stop powers down scan DAC, ADC
// [RQ5] Serial sleeps after 6 idle symbols
// [RQ6] Rx auto stop: Rx clock follows Rx enable
// [RQ7] Host enables bias 2 ms beforehand
// [RQ8] Low four bits power aux DACs 4..1
// [RQ9] Top loopback bit bypasses Rx ADC filter
// [RQ10] IIR bypass: 32 kHz, 16-bit codec samples
// [RQ11] Codec and Tx-to-Rx analogue loopbacks
// [RQ12] Separate Rx and Tx access point enables
// [RQ13] Digital loopback sends alternating I/Q samples
// [RQ14] Rate code selects MCLK/512 down to /4
// [RQ15] Direction change waits for scan end
// [RQ16] Auto cycle sweeps up and down forever
// [RQ17] Source bit picks memory or DAC1 register
// [RQ18] Channel enables apply at next conversion
// [RQ19] ADC at MCLK/8, 88 cycles, or halved
// [RQ20] Continuous bit converts channels repeatedly
// [RQ21] Start bit runs one pass, self-clears
// [RQ22] ADC idles powered down, two-period warm-up
// [RQ23] Six byte-wide read/write control registers
`ifndef PLAC_DEFS_SVH
`define PLAC_DEFS_SVH
// Register indices; byte address is index times four
`define PLAC_IDX_CLK 6'h11
`define PLAC_IDX_PWR 6'h12
`define PLAC_IDX_LOOP 6'h13
`define PLAC_IDX_SCAN 6'h14
`define PLAC_IDX_CHAN 6'h15
`define PLAC_IDX_RUN 6'h16
`define PLAC_RST_VAL 8'h00
// Clock gating fields
`define PLAC_CLK_TX_AUTO 5
`define PLAC_CLK_FIFO_OFF 4
`define PLAC_CLK_RXPORT 3
`define PLAC_CLK_AUX 2
`define PLAC_CLK_SER_AUTO 1
`define PLAC_CLK_RX_AUTO 0
// Power fields
`define PLAC_PWR_BIAS 4
// Loopback fields
`define PLAC_LB_RXFILT 7
`define PLAC_LB_IIR 5
`define PLAC_LB_CODEC 4
`define PLAC_LB_ANALOG 3
`define PLAC_LB_RXACC 2
`define PLAC_LB_TXACC 1
`define PLAC_LB_DIGITAL 0
// Scan fields
`define PLAC_SCAN_RATE_HI 5
`define PLAC_SCAN_RATE_LO 3
`define PLAC_SCAN_UP 2
`define PLAC_SCAN_CYCLE 1
`define PLAC_SCAN_SRC 0
// Run fields
`define PLAC_RUN_SLOW 2
`define PLAC_RUN_CONT 1
`define PLAC_RUN_START 0
// Timing counts in symbols, master clock cycles and conversion periods, and the channel count
`define PLAC_SER_IDLE_SYM 3'h6
`define PLAC_CONV_FAST 8'h58
`define PLAC_CONV_SLOW 8'hB0
`define PLAC_ADC_DIV_FAST 4'h7
`define PLAC_ADC_DIV_SLOW 4'hF
`define PLAC_SCAN_DIV_MAX 9'h1FF
`define PLAC_WARM_PERIODS 2'h2
`define PLAC_NUM_CHAN 6
`endif

// *** hdl/plac_pkg.sv ***
`default_nettype none
package plac_pkg;
    typedef enum logic [1:0] {
        PLAC_ADC_IDLE = 2'b00,
        PLAC_ADC_WARM = 2'b01,
        PLAC_ADC_CONV = 2'b10
    } plac_adc_state_t;

    typedef struct packed {
        logic tx_clk_en;
        logic rx_clk_en;
        logic fifo_clk_en;
        logic rx_port_pwr;
        logic serial_pwr;
        logic bias_en;
        logic [3:0] aux_dac_pwr;
        logic scan_dac_pwr;
    } plac_power_t;

    typedef struct packed {
        logic rx_filter_bypass;
        logic iir_bypass;
        logic codec_rate_32k;
        logic codec_16bit;
        logic codec_loop;
        logic analog_loop;
        logic rx_access_wr_en;
        logic tx_access_wr_en;
        logic digital_loop;
    } plac_route_t;

    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } plac_iq_t;
endpackage : plac_pkg
`default_nettype wire

// *** test/power_loopback_aux_control_tb_top.sv ***
`default_nettype none
module power_loopback_aux_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import plac_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic tx_path_en_i, rx_path_en_i, rx_path_active_i, sclk_div4_i, symbol_tick_i, sample_tick_i;
    logic [2:0] frame_sync_i, adc_chan_o;
    plac_iq_t tx_op_i, rx_data_i;
    logic [15:0] rx_port_data_o;
    logic rx_port_q_o, adc_pwr_o, adc_clk_o, adc_converting_o, adc_done_o;
    logic [9:0] ram_data_i, dac1_value_i, dac1_data_o;
    logic [5:0] ram_addr_o, a0;
    plac_power_t power_o;
    plac_route_t route_o;
    int mismatches, checked, n, dones, clks, cv, cs;
    logic [7:0] rd;
    plac_ctrl u_plac_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .tx_path_en_i(tx_path_en_i), .rx_path_en_i(rx_path_en_i), .rx_path_active_i(rx_path_active_i),
        .sclk_div4_i(sclk_div4_i), .symbol_tick_i(symbol_tick_i), .frame_sync_i(frame_sync_i),
        .sample_tick_i(sample_tick_i), .tx_op_i(tx_op_i), .rx_data_i(rx_data_i),
        .rx_port_data_o(rx_port_data_o), .rx_port_q_o(rx_port_q_o), .ram_data_i(ram_data_i),
        .dac1_value_i(dac1_value_i), .ram_addr_o(ram_addr_o), .dac1_data_o(dac1_data_o),
        .adc_pwr_o(adc_pwr_o), .adc_clk_o(adc_clk_o), .adc_converting_o(adc_converting_o),
        .adc_chan_o(adc_chan_o), .adc_done_o(adc_done_o), .power_o(power_o), .route_o(route_o));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask : cyc
    // Classic single cycle; waits for ack, never assumes latency
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic sym(input int k);
        repeat (k) begin
            @(posedge clk_i) symbol_tick_i <= 1'b1;
            @(posedge clk_i) symbol_tick_i <= 1'b0;
        end
    endtask : sym
    task automatic samp;
        @(posedge clk_i) sample_tick_i <= 1'b1;
        @(posedge clk_i) sample_tick_i <= 1'b0;
        @(posedge clk_i);
    endtask : samp
    // Window count of powered cycles and finished channels
    task automatic adc(input logic [7:0] v, input int lim);
        wb(1'b1, 8'h58, v);
        {n, dones, clks, cv, cs} = '0;
        repeat (lim) begin
            @(posedge clk_i);
            n += int'(adc_pwr_o === 1'b1);
            dones += int'(adc_done_o === 1'b1);
            clks += int'(adc_clk_o === 1'b1);
            cv += int'(adc_converting_o === 1'b1);
            cs += (adc_done_o === 1'b1) ? int'(adc_chan_o) : 0;
        end
    endtask : adc
    initial begin
        // Bias settling alone takes 50000 cycles
        repeat (75000) @(posedge clk_i);
        mismatches++;
        test_done();
    end
    initial begin
        {cyc_i, stb_i, we_i, symbol_tick_i, sample_tick_i, sclk_div4_i, rx_path_active_i} = '0;
        {tx_path_en_i, rx_path_en_i, adr_i, dat_i, frame_sync_i} = '0;
        sel_i = 4'hF;
        tx_op_i = '{i: 16'h1111, q: 16'h2222};
        rx_data_i = '{i: 16'h3333, q: 16'h4444};
        ram_data_i = 10'h2AA;
        dac1_value_i = 10'h155;
        rst_i = 1'b1;
        cyc(8);
        rst_i <= 1'b0;
        for (int r = 0; r < 6; r++) begin
            wb(1'b0, 8'h44 + 8'(4 * r), 8'h00);
            chk(rd, 8'h00);
            wb(1'b1, 8'h44 + 8'(4 * r), 8'h3C);
            wb(1'b0, 8'h44 + 8'(4 * r), 8'h00);
            chk(rd, 8'h3C);
            wb(1'b1, 8'h44 + 8'(4 * r), 8'h00);
        end
        wb(1'b1, 8'h60, 8'hFF);
        wb(1'b0, 8'h60, 8'h00);
        chk(rd, 8'h00);
        $display("test registers done");
        wb(1'b1, 8'h44, 8'h21);
        rx_path_en_i <= 1'b1;
        cyc(2);
        chk({power_o.tx_clk_en, power_o.rx_clk_en}, 2'b01);
        tx_path_en_i <= 1'b1;
        rx_path_en_i <= 1'b0;
        cyc(2);
        chk({power_o.tx_clk_en, power_o.rx_clk_en}, 2'b10);
        wb(1'b1, 8'h44, 8'h18);
        cyc(2);
        chk({power_o.fifo_clk_en, power_o.rx_port_pwr}, 2'b00);
        rx_path_active_i <= 1'b1;
        cyc(2);
        chk(power_o.rx_port_pwr, 1'b1);
        wb(1'b1, 8'h44, 8'h02);
        sclk_div4_i <= 1'b1;
        sym(5);
        chk(power_o.serial_pwr, 1'b1);
        sym(1);
        cyc(1);
        chk(power_o.serial_pwr, 1'b0);
        frame_sync_i <= 3'b010;
        cyc(3);
        chk(power_o.serial_pwr, 1'b1);
        $display("test clock gating done");
        wb(1'b1, 8'h48, 8'h1F);
        cyc(2);
        chk({power_o.bias_en, power_o.aux_dac_pwr}, 5'h1F);
        wb(1'b1, 8'h48, 8'h08);
        cyc(2);
        chk({power_o.bias_en, power_o.aux_dac_pwr}, 5'h08);
        wb(1'b1, 8'h4C, 8'hBE);
        cyc(2);
        chk(route_o, 9'h1FE);
        wb(1'b1, 8'h4C, 8'h01);
        cyc(2);
        chk(route_o, 9'h001);
        samp();
        chk({rx_port_q_o, rx_port_data_o}, 17'h0_1111);
        samp();
        chk({rx_port_q_o, rx_port_data_o}, 17'h1_2222);
        wb(1'b1, 8'h4C, 8'h00);
        samp();
        chk({rx_port_q_o, rx_port_data_o}, 17'h0_3333);
        $display("test routing done");
        wb(1'b1, 8'h48, 8'h18);
        cyc(50000);
        wb(1'b1, 8'h54, 8'h05);
        adc(8'h01, 1600);
        chk(n > 699 && n < 709, 1'b1);
        chk({16'(dones), 16'(cs)}, 32'h0002_0002);
        chk({16'(clks), 16'(cv)}, 32'h0058_00B0);
        wb(1'b0, 8'h58, 8'h00);
        chk(rd, 8'h00);
        adc(8'h05, 1600);
        chk(n > 1403 && n < 1413, 1'b1);
        chk({16'(dones), 16'(cs)}, 32'h0002_0002);
        chk({16'(clks), 16'(cv)}, 32'h0058_0160);
        adc(8'h02, 1500);
        chk({n > 1495, dones > 3}, 2'b11);
        wb(1'b1, 8'h44, 8'h04);
        cyc(3);
        chk({adc_pwr_o, power_o.scan_dac_pwr}, 2'b00);
        // Stop continuous mode first so lifting the aux stop starts nothing
        wb(1'b1, 8'h58, 8'h00);
        wb(1'b1, 8'h44, 8'h00);
        $display("test converter done");
        cyc(2);
        chk(dac1_data_o, 10'h155);
        // One tick at the bottom adopts the up direction before stepping is timed
        wb(1'b1, 8'h50, 8'h35);
        cyc(8);
        // Free-running divider: any window of one period holds one step
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, 8'h50, {2'b00, 3'(c), 3'b101});
            cyc(512 >> c);
            a0 = ram_addr_o;
            cyc(512 >> c);
            chk(ram_addr_o, a0 + 6'h01);
        end
        chk(dac1_data_o, 10'h2AA);
        wb(1'b1, 8'h50, 8'h39);
        cyc(4);
        a0 = ram_addr_o;
        cyc(4);
        chk(ram_addr_o, a0 + 6'h01);
        cyc(600);
        chk(ram_addr_o, 6'h00);
        wb(1'b1, 8'h50, 8'h3B);
        cyc(300);
        a0 = ram_addr_o;
        cyc(4);
        chk(ram_addr_o, 6'(a0 - 6'h01));
        $display("test scan done");
        test_done();
    end
endmodule : power_loopback_aux_control_tb_top
`default_nettype wire
